/* src/qbp_top.sv */
// quasi-bidirectional ports one and three, address-high port, edge irqs
// assumes synchronous pin inputs, weak pullups on the board wires,
// and an avalon-mm master on the register side
//
// Behaviour
// R1: third port resets high via weak pullup
// R2: latch high pin is input, reads pin
// R3: writing 0 holds strong pulldown until 1
// R4: 0-to-1 write pulses strong high driver
// R5: afterwards weak pullup high, usable as input
// R6: address port drives address bits 15..8
// R7: address latch value reaches pins only in indirect moves
// R8: indirect external moves use latch as upper
// R9: pin bit i carries address bit 8+i
// R10: irq3 and irq5 detect falling edges
// R11: irq4 detects rising edges
// R12: port3 bits 0-3: rx, tx, irq0, irq1
// R13: bit4 timer0 in, bit5 timer1/clock out
// R14: bits 6,7 carry write and read strobes
// R15: first port resets high, quasi-bidirectional too
// R16: irq2 detects rising edges
// R17: latch or alternate low drives pin low
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ps
`include "qbp_params.svh"

module qbp_top (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // interrupt
    output logic             irq,
    // first port pins
    input  wire logic [7:0]  p1_pin_in,
    output logic      [7:0]  p1_pin_out,
    output logic      [7:0]  p1_pin_oe,
    // third port pins
    input  wire logic [7:0]  p3_pin_in,
    output logic      [7:0]  p3_pin_out,
    output logic      [7:0]  p3_pin_oe,
    // address-high port pins, output only
    output logic      [7:0]  upper_address_byte,
    // memory interface side
    input  wire logic        ext_mem_access,
    input  wire logic [7:0]  mem_addr_hi,
    input  wire logic        external_data_move_instr,
    input  wire logic        wr_strobe_n,
    input  wire logic        rd_strobe_n,
    // alternate outputs from peripherals, high when idle
    input  wire logic        serial0_tx_out,
    input  wire logic        clk_out_en,
    input  wire logic        clk_out_val,
    // alternate inputs to peripherals
    output logic             serial0_rx_in,
    output logic             ext_irq0_in,
    output logic             ext_irq1_in,
    output logic             timer0_ext_in,
    output logic             timer1_in_or_clk_out,
    // edge pulses towards the interrupt controller
    output logic             ext_irq2_rise,
    output logic             ext_irq3_fall,
    output logic             ext_irq4_rise,
    output logic             ext_irq5_fall
);

    // ======================================================================
    // declarations
    qbp_pkg::qbp_top_st_t st_q;      // registered state
    qbp_pkg::qbp_top_st_t st_d;      // next state
    logic                 req;       // bus request present
    logic                 wr_go;     // write takes effect this edge
    logic [3:0]           edge_evt;  // edge pulses, irq2 in bit 0
    logic [7:0]           p3_alt;    // alternate outputs on port three
    logic [7:0]           p1_alt;    // first port has no alternates here

    assign req   = avs_read || avs_write;
    assign wr_go = st_q.ack && avs_write && avs_byteenable[0];

    // ======================================================================
    // alternate output functions on port three
    // bit1 serial tx, bit5 clock out, bit6 write strobe, bit7 read strobe
    assign p3_alt = {rd_strobe_n,                            // [R14]
                     wr_strobe_n,                            // [R14]
                     !clk_out_en || clk_out_val,             // [R13]
                     3'b111,
                     serial0_tx_out,                         // [R12]
                     1'b1};
    assign p1_alt = 8'hFF;

    // ======================================================================
    // pin cells, one per quasi-bidirectional bit
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pins
            // first port bit
            qbp_pin u_p1 (
                .core_clk (core_clk),
                .arst_n   (arst_n),
                .latch    (st_q.port1[gi]),
                .alt      (p1_alt[gi]),
                .pin_out  (p1_pin_out[gi]),
                .pin_oe   (p1_pin_oe[gi])
            );  // [R15]
            // third port bit
            qbp_pin u_p3 (
                .core_clk (core_clk),
                .arst_n   (arst_n),
                .latch    (st_q.port3[gi]),
                .alt      (p3_alt[gi]),
                .pin_out  (p3_pin_out[gi]),
                .pin_oe   (p3_pin_oe[gi])
            );
        end
    endgenerate

    // ======================================================================
    // edge detectors on first port bits 4 to 7
    qbp_edge #(.RISE(1'b1)) u_irq2 (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .sig_in   (st_q.p1_pins[4]),
        .pulse    (edge_evt[0])
    );  // [R16]

    qbp_edge #(.RISE(1'b0)) u_irq3 (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .sig_in   (st_q.p1_pins[5]),
        .pulse    (edge_evt[1])
    );  // [R10]

    qbp_edge #(.RISE(1'b1)) u_irq4 (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .sig_in   (st_q.p1_pins[6]),
        .pulse    (edge_evt[2])
    );  // [R11]

    qbp_edge #(.RISE(1'b0)) u_irq5 (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .sig_in   (st_q.p1_pins[7]),
        .pulse    (edge_evt[3])
    );  // [R10]

    // ======================================================================
    // next state of the whole block
    always_comb begin
        st_d = st_q;

        // sample the real pin levels, never the latches
        st_d.p1_pins = p1_pin_in;    // [R2]
        st_d.p3_pins = p3_pin_in;    // [R2]

        // address pins follow the memory cycle only
        if (ext_mem_access) begin
            if (external_data_move_instr) begin
                st_d.upper = st_q.addr_hi;     // [R8]
            end else begin
                st_d.upper = mem_addr_hi;      // [R6]
            end
        end

        // bus: one wait cycle, answer in the next
        st_d.ack   = req && !st_q.ack;
        st_d.rdata = 32'h0000_0000;
        if (req && !st_q.ack && avs_read) begin
            unique case (avs_address)
                `QBP_A_PORT1_LATCH:   st_d.rdata = {24'h00_0000, st_q.port1};
                `QBP_A_ADDR_HI_LATCH: st_d.rdata = {24'h00_0000, st_q.addr_hi};
                `QBP_A_PORT3_LATCH:   st_d.rdata = {24'h00_0000, st_q.port3};
                `QBP_A_PORT1_PINS:    st_d.rdata = {24'h00_0000, st_q.p1_pins};
                `QBP_A_PORT3_PINS:    st_d.rdata = {24'h00_0000, st_q.p3_pins};
                `QBP_A_IRQ_STATUS:    st_d.rdata = {28'h000_0000, st_q.ist};
                `QBP_A_IRQ_ENABLE:    st_d.rdata = {28'h000_0000, st_q.ien};
                // clear register and holes read zero
                default:              st_d.rdata = 32'h0000_0000;
            endcase
        end

        // writes land on the edge where waitrequest is low
        if (wr_go) begin
            unique case (avs_address)
                `QBP_A_PORT1_LATCH: begin
                    st_d.port1   = avs_writedata[7:0];     // [R15]
                    st_d.wr_seen = 1'b1;
                end
                `QBP_A_ADDR_HI_LATCH: begin
                    st_d.addr_hi = avs_writedata[7:0];     // [R7]
                end
                `QBP_A_PORT3_LATCH: begin
                    st_d.port3   = avs_writedata[7:0];     // [R3]
                    st_d.wr_seen = 1'b1;
                end
                `QBP_A_IRQ_ENABLE: begin
                    st_d.ien = avs_writedata[3:0];
                end
                // read-only, clear and unmapped writes change nothing here
                default: begin
                end
            endcase
        end

        // sticky status: a new edge wins over a clear in the same cycle
        st_d.ist = st_q.ist;
        if (wr_go && avs_address == `QBP_A_IRQ_CLEAR) begin
            st_d.ist = st_q.ist & ~avs_writedata[3:0];
        end
        st_d.ist = st_d.ist | edge_evt;

        // level interrupt while an enabled status bit is set
        st_d.irq = |(st_d.ist & st_d.ien);
    end

    // ======================================================================
    // state register; latches reset high so every port one and three pin floats on the pullup
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q         <= '0;
            st_q.port1   <= `QBP_LATCH_RST;   // [R15]
            st_q.port3   <= `QBP_LATCH_RST;   // [R1]
            st_q.addr_hi <= `QBP_LATCH_RST;
            st_q.p1_pins <= `QBP_LATCH_RST;
            st_q.p3_pins <= `QBP_LATCH_RST;
            st_q.ist     <= `QBP_IRQ_RST;
            st_q.ien     <= `QBP_IRQ_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ======================================================================
    // outputs
    assign avs_waitrequest    = req && !st_q.ack;
    assign avs_readdata       = st_q.rdata;
    assign irq                = st_q.irq;
    assign upper_address_byte = st_q.upper;   // bit i is address 8+i [R9]

    // alternate inputs taken from the sampled pins
    assign serial0_rx_in        = st_q.p3_pins[0];   // [R12]
    assign ext_irq0_in          = st_q.p3_pins[2];   // [R12]
    assign ext_irq1_in          = st_q.p3_pins[3];   // [R12]
    assign timer0_ext_in        = st_q.p3_pins[4];   // [R13]
    assign timer1_in_or_clk_out = st_q.p3_pins[5];   // [R13]

    // edge pulses towards the interrupt controller
    assign ext_irq2_rise = edge_evt[0];
    assign ext_irq3_fall = edge_evt[1];
    assign ext_irq4_rise = edge_evt[2];
    assign ext_irq5_fall = edge_evt[3];

    // ======================================================================
    // checks
    property p_reset_high;
        @(posedge core_clk) disable iff (!arst_n)
            !st_q.wr_seen |-> (p3_pin_oe & ~p3_pin_out & ~p3_alt) == 8'h00
                              && st_q.port3 == 8'hFF && st_q.port1 == 8'hFF;
    endproperty
    a_reset_high: assert property (p_reset_high) else $error("port not high after reset"); // [R1]

    property p_pin_read;
        @(posedge core_clk) disable iff (!arst_n)
            1'b1 |=> st_q.p1_pins == $past(p1_pin_in) && st_q.p3_pins == $past(p3_pin_in);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin level not sampled"); // [R2]

    property p_addr_out;
        @(posedge core_clk) disable iff (!arst_n)
            ext_mem_access && !external_data_move_instr |=> upper_address_byte == $past(mem_addr_hi);
    endproperty
    a_addr_out: assert property (p_addr_out) else $error("address byte not driven"); // [R6]

    property p_addr_hold;
        @(posedge core_clk) disable iff (!arst_n)
            !ext_mem_access |=> $stable(upper_address_byte);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address pins moved idle"); // [R7]

    property p_ind;
        @(posedge core_clk) disable iff (!arst_n)
            ext_mem_access && external_data_move_instr |=> upper_address_byte == $past(st_q.addr_hi);
    endproperty
    a_ind: assert property (p_ind) else $error("indirect move upper byte wrong"); // [R8]

    property p_strobe;
        @(posedge core_clk) disable iff (!arst_n)
            !wr_strobe_n || !rd_strobe_n |-> p3_pin_oe[7:6] != 2'b00
                && (p3_pin_out[7:6] & {~rd_strobe_n, ~wr_strobe_n}) == 2'b00;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe not on pin"); // [R14]

    property p_rx;
        @(posedge core_clk) disable iff (!arst_n) ##1 serial0_rx_in == $past(p3_pin_in[0]);
    endproperty
    a_rx: assert property (p_rx) else $error("receive input not routed"); // [R12]

    property p_irq3;
        @(posedge core_clk) disable iff (!arst_n)
            $fell(p1_pin_in[5]) |-> ##3 st_q.ist[1];
    endproperty
    a_irq3: assert property (p_irq3) else $error("falling edge not latched"); // [R10]

    c_ind:  cover property (@(posedge core_clk) disable iff (!arst_n)
                            ext_mem_access && external_data_move_instr);
    c_irq:  cover property (@(posedge core_clk) disable iff (!arst_n) $rose(irq));
    c_wr:   cover property (@(posedge core_clk) disable iff (!arst_n) wr_go);

endmodule

/* inc/qbp_params.svh */
// constants of the quasi-bidirectional port block: offsets, resets, timing
// assumes a 32-bit avalon slave with byte addresses, core clock 40 MHz
`ifndef QBP_PARAMS_SVH
`define QBP_PARAMS_SVH

// ==========================================================================
// register byte offsets
`define QBP_A_PORT1_LATCH   5'h00
`define QBP_A_ADDR_HI_LATCH 5'h04
`define QBP_A_PORT3_LATCH   5'h08
`define QBP_A_PORT1_PINS    5'h0C
`define QBP_A_PORT3_PINS    5'h10
`define QBP_A_IRQ_STATUS    5'h14
`define QBP_A_IRQ_CLEAR     5'h18
`define QBP_A_IRQ_ENABLE    5'h1C

// ==========================================================================
// reset values
`define QBP_LATCH_RST       8'hFF
`define QBP_IRQ_RST         4'h0

// ==========================================================================
// timing: strong transition driver on time, rounded up to whole cycles
`define QBP_CLK_NS          25
`define QBP_STRONG_NS       50
`define QBP_STRONG_CYC      ((`QBP_STRONG_NS + `QBP_CLK_NS - 1) / `QBP_CLK_NS)

`endif

/* inc/qbp_pkg.sv */
// types shared by the quasi-bidirectional port block
// assumes nothing beyond a systemverilog compiler
package qbp_pkg;

    // ======================================================================
    // state of one quasi-bidirectional pin cell
    typedef struct packed {
        logic       prev;       // effective drive level one cycle ago
        logic [1:0] cnt;        // remaining strong-high cycles
    } qbp_pin_st_t;

    // ======================================================================
    // state of one edge detector
    typedef struct packed {
        logic prev;             // pin level one cycle ago
        logic pulse;            // detected edge, one cycle
    } qbp_edge_st_t;

    // ======================================================================
    // state of the port block top
    typedef struct packed {
        logic [7:0]  port1;     // first port latch
        logic [7:0]  addr_hi;   // address-high latch (indirect moves)
        logic [7:0]  port3;     // third port latch
        logic [7:0]  p1_pins;   // sampled first port pins
        logic [7:0]  p3_pins;   // sampled third port pins
        logic [7:0]  upper;     // upper address byte on the pins
        logic [3:0]  ist;       // sticky interrupt status
        logic [3:0]  ien;       // interrupt enable
        logic        irq;       // interrupt output
        logic        ack;       // bus answer cycle
        logic [31:0] rdata;     // bus read data
        logic        wr_seen;   // any port one or three latch write since reset
    } qbp_top_st_t;

endpackage

/* src/qbp_pin.sv */
// one quasi-bidirectional pin: strong pulldown, weak pullup, strong edge
// assumes the wire carries a weak pullup outside; oe low means released
`timescale 1ns/1ps
`include "qbp_params.svh"

module qbp_pin (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // drive requests
    input  wire logic latch,     // port latch bit
    input  wire logic alt,       // alternate output, high when idle
    // pin
    output logic      pin_out,   // level driven
    output logic      pin_oe     // high while driving strongly
);

    qbp_pkg::qbp_pin_st_t st_q;  // registered state
    qbp_pkg::qbp_pin_st_t st_d;  // next state
    logic                 eff;   // wanted level

    // either source pulls the pin low
    assign eff = latch & alt;    // [R17]

    // ======================================================================
    // next state: arm the strong driver on a low-to-high transition
    always_comb begin
        st_d      = st_q;
        st_d.prev = eff;
        if (eff && !st_q.prev) begin
            st_d.cnt = 2'(`QBP_STRONG_CYC - 1);    // [R4]
        end else if (!eff) begin
            st_d.cnt = 2'd0;
        end else if (st_q.cnt != 2'd0) begin
            st_d.cnt = st_q.cnt - 2'd1;
        end
    end

    // pulldown while low, strong high only during the transition window
    assign pin_out = eff;
    assign pin_oe  = !eff || (st_q.cnt != 2'd0) || !st_q.prev;  // [R3] [R5]

    // ======================================================================
    // state register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '{prev: 1'b1, cnt: 2'd0};
        end else begin
            st_q <= st_d;
        end
    end

    // ======================================================================
    // checks
    property p_pulldown;
        @(posedge core_clk) disable iff (!arst_n) !latch |-> pin_oe && !pin_out;
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("latch low not driven low"); // [R3]

    property p_strong;
        @(posedge core_clk) disable iff (!arst_n)
            $rose(eff) ##1 eff |-> $past(pin_oe && pin_out) && pin_oe && pin_out;
    endproperty
    a_strong: assert property (p_strong) else $error("strong high too short"); // [R4]

    property p_weak;
        @(posedge core_clk) disable iff (!arst_n) $rose(eff) ##1 eff[*2] |-> !pin_oe;
    endproperty
    a_weak: assert property (p_weak) else $error("strong high not released"); // [R5]

    property p_alt_low;
        @(posedge core_clk) disable iff (!arst_n) !alt |-> pin_oe && !pin_out;
    endproperty
    a_alt_low: assert property (p_alt_low) else $error("alternate low not driven"); // [R17]

    c_strong: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(eff));

endmodule

/* src/qbp_edge.sv */
// edge detector giving a one-cycle pulse on the chosen edge
// assumes the input is synchronous to core_clk
`timescale 1ns/1ps

module qbp_edge #(
    parameter bit RISE = 1'b1    // 1: rising edge, 0: falling edge
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // level in, pulse out
    input  wire logic sig_in,
    output logic      pulse
);

    qbp_pkg::qbp_edge_st_t st_q;  // registered state
    qbp_pkg::qbp_edge_st_t st_d;  // next state

    // ======================================================================
    // compare with the previous level
    always_comb begin
        st_d       = st_q;
        st_d.prev  = sig_in;
        st_d.pulse = RISE ? (sig_in && !st_q.prev) : (!sig_in && st_q.prev);
    end

    assign pulse = st_q.pulse;

    // ======================================================================
    // state register; idle level high so reset makes no edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '{prev: 1'b1, pulse: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // ======================================================================
    // checks
    property p_edge;
        @(posedge core_clk) disable iff (!arst_n)
            (RISE ? $rose(sig_in) : $fell(sig_in)) |=> pulse;
    endproperty
    a_edge: assert property (p_edge) else $error("edge missed"); // [R10] [R11] [R16]

endmodule

/* verification/qbp_board.sv */
// board model: weak pullups plus outside circuits that pull pins low
// assumes pin_oe high means the port drives the wire strongly
`timescale 1ns/1ps

module qbp_board (
    // port side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    // outside circuit pulling low
    input  wire logic [7:0] ext_low,
    // resolved wire level
    output logic      [7:0] pin_in
);
    // strong drive wins, else a pull-low overdrives the weak pullup
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : !ext_low[i];
        end
    end
endmodule

/* verification/tb.sv */
// self-checking bench of the port block, queue of expected results
// assumes qbp_top, qbp_board and the offsets of qbp_params.svh
`timescale 1ns/1ps
`include "qbp_params.svh"

module tb;
    // ======================================================================
    // stimulus and observed signals
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, mm;
    logic        avs_waitrequest, irq;
    logic [7:0]  p1_in, p1_out, p1_oe, p3_in, p3_out, p3_oe, upper;
    logic [7:0]  p1_low = 8'h00, p3_low = 8'h00, mem_hi = 8'h00;
    logic        mem_acc = 1'b0, mov_ind = 1'b0, wr_n = 1'b1, rd_n = 1'b1;
    logic        rx, irq0, irq1, ti0, ti1, e2, e3, e4, e5;
    logic [15:0] rnd = 16'h1AEA;       // lfsr seed
    int          error_cnt = 0, tests_run = 0, cyc = 0;
    // expectation queue: name, value, mask, source
    string       nm_q[$];
    logic [31:0] ex_q[$], mk_q[$];
    bit [1:0]    sl_q[$];
    event        snap;
    wire  [31:0] obs1 = {p1_oe, p1_out, p3_oe, p3_out};
    wire  [31:0] obs2 = {16'h0000, upper, irq, rx, ti0, irq0, irq1, ti1, 2'h0};

    always #12.5 core_clk = ~core_clk;

    qbp_top i_dut (
        .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq),
        .p1_pin_in(p1_in), .p1_pin_out(p1_out), .p1_pin_oe(p1_oe),
        .p3_pin_in(p3_in), .p3_pin_out(p3_out), .p3_pin_oe(p3_oe),
        .upper_address_byte(upper), .ext_mem_access(mem_acc), .mem_addr_hi(mem_hi),
        .external_data_move_instr(mov_ind), .wr_strobe_n(wr_n), .rd_strobe_n(rd_n),
        .serial0_tx_out(wr_n), .clk_out_en(1'b1), .clk_out_val(rd_n),
        .serial0_rx_in(rx), .ext_irq0_in(irq0), .ext_irq1_in(irq1),
        .timer0_ext_in(ti0), .timer1_in_or_clk_out(ti1), .ext_irq2_rise(e2),
        .ext_irq3_fall(e3), .ext_irq4_rise(e4), .ext_irq5_fall(e5));
    qbp_board i_b1 (.pin_out(p1_out), .pin_oe(p1_oe), .ext_low(p1_low), .pin_in(p1_in));
    qbp_board i_b3 (.pin_out(p3_out), .pin_oe(p3_oe), .ext_low(p3_low), .pin_in(p3_in));

    // ======================================================================
    // helpers
    function logic [15:0] lfsr(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task chk(string n, logic [31:0] e, logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task note(string n, logic [31:0] e, logic [31:0] m, bit [1:0] s);
        nm_q.push_back(n);
        ex_q.push_back(e & m);
        mk_q.push_back(m);
        sl_q.push_back(s);
    endtask

    // one avalon access, held until waitrequest is seen low
    task bus(bit w, logic [4:0] a, logic [31:0] d);
        @(posedge core_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        @(posedge core_clk);
        while (avs_waitrequest) @(posedge core_clk);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task rd(string n, logic [4:0] a, logic [31:0] e);
        note(n, e, 32'hFFFF_FFFF, 2'd0);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // pin snapshot once the edge's updates have landed
    task look(string n, logic [31:0] e, logic [31:0] m, bit [1:0] s);
        #1;
        note(n, e, m, s);
        -> snap;
    endtask

    task conclude();
        $display("counts: tests %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ======================================================================
    // monitors: read data at the answer edge, pin snapshots on request
    always @(posedge core_clk) begin
        if (avs_read && !avs_waitrequest && nm_q.size() > 0) begin
            mm = mk_q.pop_front();
            void'(sl_q.pop_front());
            chk(nm_q.pop_front(), ex_q.pop_front(), avs_readdata & mm);
        end
    end
    always @(snap) begin
        mm = mk_q.pop_front();
        chk(nm_q.pop_front(), ex_q.pop_front(), (sl_q.pop_front() == 2'd1 ? obs1 : obs2) & mm);
    end
    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            conclude();
        end
    end

    // ======================================================================
    // main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        look("reset pins", 32'h00FF_00FF, 32'hFFFF_FFFF, 2'd1);
        look("reset upper", 32'h0000_0000, 32'h0000_FF80, 2'd2);
        $display("test reset done");
        // third port: pulldown, strong edge, weak high
        bus(1'b1, `QBP_A_PORT3_LATCH, 32'h0000_0000);
        look("p3 pulldown", 32'h0000_FF00, 32'h0000_FFFF, 2'd1);
        repeat (3) @(posedge core_clk);
        look("p3 held", 32'h0000_FF00, 32'h0000_FFFF, 2'd1);
        bus(1'b1, `QBP_A_PORT3_LATCH, 32'h0000_00FF);
        look("p3 strong 1", 32'h0000_FFFF, 32'h0000_FFFF, 2'd1);
        @(posedge core_clk);
        look("p3 strong 2", 32'h0000_FFFF, 32'h0000_FFFF, 2'd1);
        @(posedge core_clk);
        look("p3 weak", 32'h0000_00FF, 32'h0000_FFFF, 2'd1);
        rnd = lfsr(rnd);
        bus(1'b1, `QBP_A_PORT1_LATCH, {24'h00_0000, rnd[7:0]});
        look("p1 drive", {~rnd[7:0], rnd[7:0], 16'h0000}, 32'hFFFF_0000, 2'd1);
        bus(1'b1, `QBP_A_PORT1_LATCH, 32'h0000_00FF);
        $display("test drive done");
        // inputs overdriving the weak pullup, then strobe outputs driving port three low
        @(posedge core_clk);
        p3_low <= 8'h11;
        repeat (3) @(posedge core_clk);
        rd("p3 pins", `QBP_A_PORT3_PINS, 32'h0000_00EE);
        look("alt inputs", 32'h0000_001C, 32'h0000_007C, 2'd2);
        @(posedge core_clk);
        p3_low <= 8'h00;
        wr_n <= 1'b0;
        rd_n <= 1'b0;
        look("strobes", 32'h0000_E200, 32'h0000_E2E2, 2'd1);
        @(posedge core_clk);
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        $display("test inputs done");
        // address-high port
        rnd = lfsr(rnd);
        bus(1'b1, `QBP_A_ADDR_HI_LATCH, {24'h00_0000, rnd[7:0]});
        repeat (2) @(posedge core_clk);
        look("latch hidden", 32'h0000_0000, 32'h0000_FF00, 2'd2);
        @(posedge core_clk);
        mem_acc <= 1'b1;
        mem_hi <= rnd[15:8];
        repeat (2) @(posedge core_clk);
        look("upper", {16'h0000, rnd[15:8], 8'h00}, 32'h0000_FF00, 2'd2);
        @(posedge core_clk);
        mov_ind <= 1'b1;
        repeat (2) @(posedge core_clk);
        look("indirect", {16'h0000, rnd[7:0], 8'h00}, 32'h0000_FF00, 2'd2);
        @(posedge core_clk);
        mem_acc <= 1'b0;
        mov_ind <= 1'b0;
        $display("test address done");
        // edge interrupts, mask and clear
        bus(1'b1, `QBP_A_IRQ_CLEAR, 32'h0000_000F);
        @(posedge core_clk);
        p1_low <= 8'hF0;
        repeat (4) @(posedge core_clk);
        rd("falls", `QBP_A_IRQ_STATUS, 32'h0000_000A);
        bus(1'b1, `QBP_A_IRQ_CLEAR, 32'h0000_000F);
        @(posedge core_clk);
        p1_low <= 8'h00;
        repeat (4) @(posedge core_clk);
        rd("rises", `QBP_A_IRQ_STATUS, 32'h0000_0005);
        look("irq masked", 32'h0000_0000, 32'h0000_0080, 2'd2);
        bus(1'b1, `QBP_A_IRQ_ENABLE, 32'h0000_0004);
        repeat (2) @(posedge core_clk);
        look("irq on", 32'h0000_0080, 32'h0000_0080, 2'd2);
        bus(1'b1, `QBP_A_IRQ_CLEAR, 32'h0000_0004);
        repeat (2) @(posedge core_clk);
        look("irq off", 32'h0000_0000, 32'h0000_0080, 2'd2);
        rd("enable", `QBP_A_IRQ_ENABLE, 32'h0000_0004);
        $display("test interrupts done");
        repeat (2) @(posedge core_clk);
        conclude();
    end
endmodule
